//--- core/csbp_pkg.sv
package csbp_pkg;

    // shared bus geometry
    localparam int CSBP_DATA_W = 32;
    localparam int CSBP_ADDR_W = 28;
    localparam int CSBP_HI_W = 4;
    localparam int CSBP_LANE_W = 4;

    // external processor access width codes
    localparam logic [1:0] CSBP_SZ_LONG = 2'h0;
    localparam logic [1:0] CSBP_SZ_BYTE = 2'h1;
    localparam logic [1:0] CSBP_SZ_WORD = 2'h2;
    localparam logic [1:0] CSBP_SZ_LINE = 2'h3;

    // transfer type of an ordinary access
    localparam logic [1:0] CSBP_TT_NORMAL = 2'h0;

    // device resource window inside the shared address space
    localparam logic [27:0] CSBP_OWN_BASE = 28'hFFF0000;
    localparam logic [27:0] CSBP_OWN_MASK = 28'hFFF0000;
    localparam logic [3:0] CSBP_OWN_HI = 4'h0;
    // memory controller window
    localparam logic [27:0] CSBP_MEM_BASE = 28'h0000000;
    localparam logic [27:0] CSBP_MEM_MASK = 28'h8000000;

    // wait cycles the memory controller inserts before acknowledging
    localparam logic [2:0] CSBP_MEM_WAIT = 3'h2;
    // beats in a line transfer, less one
    localparam logic [1:0] CSBP_LINE_LAST = 2'h3;

    // byte lanes, lane 3 = data[31:24] = byte address 0
    function automatic logic [3:0] csbp_lanes(input logic [1:0] sz, input logic [1:0] a);
        logic [3:0] r;
        r = 4'hF;
        case (sz)
            CSBP_SZ_BYTE: r = 4'h8 >> a;
            CSBP_SZ_WORD: r = a[1] ? 4'h3 : 4'hC;
            default: r = 4'hF;
        endcase
        return r;
    endfunction

    function automatic logic csbp_in_win(input logic [27:0] a, input logic [27:0] base,
                                         input logic [27:0] mask);
        return (a & mask) == base;
    endfunction

endpackage

//--- core/csbp_bus_if.sv
`timescale 1ns/10ps
interface csbp_bus_if;
    import csbp_pkg::*;

    // host-driven lines
    logic transfer_start_n;
    logic [CSBP_ADDR_W-1:0] addr;
    logic rw;
    logic [1:0] access_width_code;
    logic [1:0] transfer_type_code;
    logic [2:0] transfer_mode_code;

    // shared data lines
    logic [CSBP_DATA_W-1:0] host_d_o;
    logic host_d_oe;
    logic [CSBP_DATA_W-1:0] dev_d_o;
    logic dev_d_oe;
    logic [CSBP_DATA_W-1:0] data;

    // strobe pins, or upper address when every address line is shared
    logic [CSBP_LANE_W-1:0] dev_we_o;
    logic dev_we_oe;
    logic [CSBP_HI_W-1:0] host_hi_o;
    logic host_hi_oe;
    logic [CSBP_LANE_W-1:0] we_pins;

    // device-driven termination lines, pulled up when undriven
    logic dev_ack_o;
    logic dev_ack_oe;
    logic dev_tea_o;
    logic dev_tea_oe;
    logic dev_bi_o;
    logic dev_bi_oe;
    logic transfer_ack_n;
    logic transfer_error_ack_n;
    logic burst_inhibit_n;

    assign data = dev_d_oe ? dev_d_o : (host_d_oe ? host_d_o : '0);
    assign we_pins = dev_we_oe ? dev_we_o : (host_hi_oe ? host_hi_o : 4'hF);
    assign transfer_ack_n = dev_ack_oe ? dev_ack_o : 1'b1;
    assign transfer_error_ack_n = dev_tea_oe ? dev_tea_o : 1'b1;
    assign burst_inhibit_n = dev_bi_oe ? dev_bi_o : 1'b1;

    modport dev (
        input transfer_start_n, addr, rw, access_width_code, transfer_type_code,
        input transfer_mode_code, data, we_pins,
        output dev_d_o, dev_d_oe, dev_we_o, dev_we_oe,
        output dev_ack_o, dev_ack_oe, dev_tea_o, dev_tea_oe, dev_bi_o, dev_bi_oe
    );

    modport host (
        output transfer_start_n, addr, rw, access_width_code, transfer_type_code,
        output transfer_mode_code, host_d_o, host_d_oe, host_hi_o, host_hi_oe,
        input data, transfer_ack_n, transfer_error_ack_n, burst_inhibit_n
    );

endinterface

//--- core/csbp_device.sv
// What this block does
// - core disabled: serve external processor as slave
// - all data lines shared with processor
// - no half-width data bus in slave mode
// - twenty-eight shared address lines decoded here
// - all address shared: strobe pins become address
// - processor-style start, ack, error, burst inhibit
// - width pins decoded with processor size encoding
// - watch address on every normal-type processor cycle in slave mode
// - start and ack lines reach device ungated
// - direction and width pins wired straight through
`timescale 1ns/10ps
module csbp_device
    import csbp_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    csbp_bus_if.dev bus,
    input wire logic slave_mode,
    input wire logic bus16_strap,
    input wire logic share_all_addr,
    output logic eff_bus16,
    output logic usr_req,
    output logic [CSBP_ADDR_W-1:0] usr_addr,
    output logic usr_write,
    output logic [CSBP_DATA_W-1:0] usr_wdata,
    output logic [CSBP_LANE_W-1:0] usr_lanes,
    output logic [2:0] usr_tm,
    input wire logic usr_ack,
    input wire logic usr_err,
    input wire logic [CSBP_DATA_W-1:0] usr_rdata,
    output logic mem_sel,
    output logic [CSBP_ADDR_W-1:0] mem_addr,
    output logic [CSBP_LANE_W-1:0] mem_lanes,
    output logic mem_write
);

    typedef enum logic [1:0] {
        CSBP_D_IDLE,
        CSBP_D_OWN,
        CSBP_D_MEM,
        CSBP_D_END
    } csbp_dst_e;

    typedef struct packed {
        csbp_dst_e st;
        logic [CSBP_ADDR_W-1:0] addr;
        logic wr;
        logic [1:0] sz;
        logic [2:0] tm;
        logic [CSBP_LANE_W-1:0] lanes;
        logic [CSBP_DATA_W-1:0] wdata;
        logic [CSBP_DATA_W-1:0] rdata;
        logic req;
        logic ack;
        logic transfer_error_ack;
        logic bi;
        logic drive_d;
        logic [CSBP_LANE_W-1:0] we_n;
        logic mem_sel;
        logic [2:0] wait_cnt;
        logic bus16;
    } csbp_dev_s;

    csbp_dev_s cur_ff;
    csbp_dev_s nxt_cur;

    logic [CSBP_HI_W-1:0] hi_addr;
    logic cyc_start;
    logic hit_own;
    logic hit_mem;

    // upper address only exists on the strobe pins when they are given up
    assign hi_addr = share_all_addr ? bus.we_pins : '0;

    // in slave mode every normal-type start is seen, whoever the target, since the line is ungated
    assign cyc_start = slave_mode && !bus.transfer_start_n
        && (bus.transfer_type_code == CSBP_TT_NORMAL);

    assign hit_own = csbp_in_win(bus.addr, CSBP_OWN_BASE, CSBP_OWN_MASK)
        && (hi_addr == CSBP_OWN_HI);
    assign hit_mem = csbp_in_win(bus.addr, CSBP_MEM_BASE, CSBP_MEM_MASK);

    always_comb
    begin
        nxt_cur = cur_ff;
        nxt_cur.req = 1'b0;
        // half-width option only honoured when the core runs the bus
        nxt_cur.bus16 = bus16_strap && !slave_mode;
        case (cur_ff.st)
            CSBP_D_IDLE:
            begin
                nxt_cur.ack = 1'b0;
                nxt_cur.transfer_error_ack = 1'b0;
                nxt_cur.bi = 1'b0;
                nxt_cur.drive_d = 1'b0;
                nxt_cur.mem_sel = 1'b0;
                nxt_cur.we_n = 4'hF;
                if (cyc_start)
                begin
                    nxt_cur.addr = bus.addr;
                    nxt_cur.wr = !bus.rw;
                    nxt_cur.sz = bus.access_width_code;
                    nxt_cur.tm = bus.transfer_mode_code;
                    // processor size code, not the native one
                    nxt_cur.lanes = csbp_lanes(bus.access_width_code,
                        bus.addr[1:0]);
                    nxt_cur.wdata = bus.data;
                    if (hit_own)
                    begin
                        nxt_cur.st = CSBP_D_OWN;
                        nxt_cur.req = 1'b1;
                    end
                    else if (hit_mem)
                    begin
                        nxt_cur.st = CSBP_D_MEM;
                        nxt_cur.mem_sel = 1'b1;
                        nxt_cur.wait_cnt = CSBP_MEM_WAIT;
                        if (!bus.rw && !share_all_addr)
                        begin
                            nxt_cur.we_n = ~csbp_lanes(bus.access_width_code,
                                bus.addr[1:0]);
                        end
                    end
                    // any other address belongs to another slave; stay idle
                end
            end
            CSBP_D_OWN:
            begin
                if (usr_ack || usr_err)
                begin
                    nxt_cur.st = CSBP_D_END;
                    nxt_cur.rdata = usr_rdata;
                    nxt_cur.ack = !usr_err;
                    nxt_cur.transfer_error_ack = usr_err;
                    // single-beat resource: lines are broken into longs
                    nxt_cur.bi = (cur_ff.sz == CSBP_SZ_LINE) && !usr_err;
                    nxt_cur.drive_d = !cur_ff.wr && !usr_err;
                end
            end
            CSBP_D_MEM:
            begin
                if (cur_ff.wait_cnt == 3'h0)
                begin
                    nxt_cur.st = CSBP_D_END;
                    nxt_cur.ack = 1'b1;
                    nxt_cur.bi = (cur_ff.sz == CSBP_SZ_LINE);
                end
                else
                begin
                    nxt_cur.wait_cnt = cur_ff.wait_cnt - 3'h1;
                end
            end
            CSBP_D_END:
            begin
                nxt_cur.st = CSBP_D_IDLE;
                nxt_cur.ack = 1'b0;
                nxt_cur.transfer_error_ack = 1'b0;
                nxt_cur.bi = 1'b0;
                nxt_cur.drive_d = 1'b0;
                nxt_cur.mem_sel = 1'b0;
                nxt_cur.we_n = 4'hF;
            end
            default:
            begin
                nxt_cur.st = CSBP_D_IDLE;
            end
        endcase
        // leaving slave mode drops any cycle in flight
        if (!slave_mode)
        begin
            nxt_cur.st = CSBP_D_IDLE;
            nxt_cur.ack = 1'b0;
            nxt_cur.transfer_error_ack = 1'b0;
            nxt_cur.bi = 1'b0;
            nxt_cur.drive_d = 1'b0;
            nxt_cur.mem_sel = 1'b0;
            nxt_cur.we_n = 4'hF;
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            cur_ff <= '{st: CSBP_D_IDLE, we_n: 4'hF, default: '0};
        end
        else if (ce)
        begin
            cur_ff <= nxt_cur;
        end
    end

    // termination lines are driven low only while asserted
    assign bus.dev_ack_o = 1'b0;
    assign bus.dev_ack_oe = cur_ff.ack;
    assign bus.dev_tea_o = 1'b0;
    assign bus.dev_tea_oe = cur_ff.transfer_error_ack;
    assign bus.dev_bi_o = 1'b0;
    assign bus.dev_bi_oe = cur_ff.bi;
    assign bus.dev_d_o = cur_ff.rdata;
    assign bus.dev_d_oe = cur_ff.drive_d;
    assign bus.dev_we_o = cur_ff.we_n;
    // strobes stop driving once they carry upper address bits
    assign bus.dev_we_oe = slave_mode && !share_all_addr;

    assign eff_bus16 = cur_ff.bus16;
    assign usr_req = cur_ff.req;
    assign usr_addr = cur_ff.addr;
    assign usr_write = cur_ff.wr;
    assign usr_wdata = cur_ff.wdata;
    assign usr_lanes = cur_ff.lanes;
    assign usr_tm = cur_ff.tm;
    assign mem_sel = cur_ff.mem_sel;
    assign mem_addr = cur_ff.addr;
    assign mem_lanes = cur_ff.lanes;
    assign mem_write = cur_ff.wr;

endmodule // csbp_device

//--- core/csbp_host.sv
`timescale 1ns/10ps
module csbp_host
    import csbp_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    csbp_bus_if.host bus,
    input wire logic share_all_addr,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [31:0] cmd_addr,
    input wire logic cmd_write,
    input wire logic [CSBP_DATA_W-1:0] cmd_wdata,
    input wire logic [1:0] cmd_size,
    input wire logic [1:0] cmd_tt,
    input wire logic [2:0] cmd_tm,
    output logic rsp_valid,
    output logic [CSBP_DATA_W-1:0] rsp_rdata,
    output logic rsp_err,
    output logic rsp_bi,
    output logic rsp_last
);

    typedef enum logic {
        CSBP_H_IDLE,
        CSBP_H_BUSY
    } csbp_hst_e;

    typedef struct packed {
        csbp_hst_e st;
        logic ts;
        logic [31:0] addr;
        logic wr;
        logic [CSBP_DATA_W-1:0] wdata;
        logic [1:0] sz;
        logic [1:0] tt;
        logic [2:0] tm;
        logic [1:0] beat;
        logic rsp;
        logic [CSBP_DATA_W-1:0] rdata;
        logic err;
        logic bi;
        logic last;
    } csbp_host_s;

    csbp_host_s cur_ff;
    csbp_host_s nxt_cur;

    assign cmd_ready = (cur_ff.st == CSBP_H_IDLE);

    always_comb
    begin
        nxt_cur = cur_ff;
        nxt_cur.ts = 1'b0;
        nxt_cur.rsp = 1'b0;
        case (cur_ff.st)
            CSBP_H_IDLE:
            begin
                if (cmd_valid)
                begin
                    nxt_cur.st = CSBP_H_BUSY;
                    nxt_cur.ts = 1'b1;
                    nxt_cur.addr = cmd_addr;
                    nxt_cur.wr = cmd_write;
                    nxt_cur.wdata = cmd_wdata;
                    nxt_cur.sz = cmd_size;
                    nxt_cur.tt = cmd_tt;
                    nxt_cur.tm = cmd_tm;
                    nxt_cur.beat = 2'h0;
                end
            end
            CSBP_H_BUSY:
            begin
                // terminations are not looked at in the start cycle itself
                if (!cur_ff.ts && !bus.transfer_error_ack_n)
                begin
                    nxt_cur.st = CSBP_H_IDLE;
                    nxt_cur.rsp = 1'b1;
                    nxt_cur.err = 1'b1;
                    nxt_cur.bi = 1'b0;
                    nxt_cur.last = 1'b1;
                    nxt_cur.rdata = '0;
                end
                else if (!cur_ff.ts && !bus.transfer_ack_n)
                begin
                    nxt_cur.rsp = 1'b1;
                    nxt_cur.err = 1'b0;
                    nxt_cur.bi = !bus.burst_inhibit_n;
                    nxt_cur.rdata = cur_ff.wr ? '0 : bus.data;
                    // inhibited line ends after its first beat
                    if (cur_ff.sz == CSBP_SZ_LINE && bus.burst_inhibit_n
                        && cur_ff.beat != CSBP_LINE_LAST)
                    begin
                        nxt_cur.beat = cur_ff.beat + 2'h1;
                        nxt_cur.last = 1'b0;
                    end
                    else
                    begin
                        nxt_cur.st = CSBP_H_IDLE;
                        nxt_cur.last = 1'b1;
                    end
                end
            end
            default:
            begin
                nxt_cur.st = CSBP_H_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            cur_ff <= '{st: CSBP_H_IDLE, default: '0};
        end
        else if (ce)
        begin
            cur_ff <= nxt_cur;
        end
    end

    assign bus.transfer_start_n = !cur_ff.ts;
    assign bus.addr = cur_ff.addr[CSBP_ADDR_W-1:0];
    assign bus.rw = !cur_ff.wr;
    assign bus.access_width_code = cur_ff.sz;
    assign bus.transfer_type_code = cur_ff.tt;
    assign bus.transfer_mode_code = cur_ff.tm;
    assign bus.host_d_o = cur_ff.wdata;
    assign bus.host_d_oe = (cur_ff.st == CSBP_H_BUSY) && cur_ff.wr;
    assign bus.host_hi_o = cur_ff.addr[31:28];
    assign bus.host_hi_oe = share_all_addr;

    assign rsp_valid = cur_ff.rsp;
    assign rsp_rdata = cur_ff.rdata;
    assign rsp_err = cur_ff.err;
    assign rsp_bi = cur_ff.bi;
    assign rsp_last = cur_ff.last;

endmodule // csbp_host

//--- test/csbp_assertions.sv
`timescale 1ns/10ps
module csbp_assertions
    import csbp_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic slave_mode,
    input wire logic share_all_addr,
    input wire logic transfer_start_n,
    input wire logic [CSBP_ADDR_W-1:0] addr,
    input wire logic rw,
    input wire logic [1:0] access_width_code,
    input wire logic [1:0] transfer_type_code,
    input wire logic dev_d_oe,
    input wire logic dev_we_oe,
    input wire logic transfer_ack_n,
    input wire logic transfer_error_ack_n,
    input wire logic burst_inhibit_n
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    ack_pulse_a: assert property (!transfer_ack_n |=> transfer_ack_n)
        else $error("transfer ack held past one cycle");
    tea_pulse_a: assert property (!transfer_error_ack_n |=> transfer_error_ack_n)
        else $error("error ack held past one cycle");
    bi_with_term_a: assert property (!burst_inhibit_n
        |-> !(transfer_ack_n && transfer_error_ack_n))
        else $error("burst inhibit without termination");
    line_inhibit_a: assert property ((!transfer_ack_n
        && access_width_code == CSBP_SZ_LINE) |-> !burst_inhibit_n)
        else $error("line acknowledged without burst inhibit");
    mem_ack_time_a: assert property ((slave_mode && !transfer_start_n && !addr[27]
        && transfer_type_code == CSBP_TT_NORMAL) |-> ##1 transfer_ack_n [*3] ##1 !transfer_ack_n)
        else $error("memory cycle ack not at fourth cycle");
    own_ack_late_a: assert property ((slave_mode && !transfer_start_n
        && (addr & CSBP_OWN_MASK) == CSBP_OWN_BASE) |=> transfer_ack_n)
        else $error("own cycle acknowledged too early");
    strobes_gone_a: assert property ((share_all_addr && $past(share_all_addr))
        |-> !dev_we_oe)
        else $error("strobes driven while address fully shared");
    strobes_kept_a: assert property ((slave_mode && !share_all_addr
        && $past(slave_mode) && !$past(share_all_addr)) |-> dev_we_oe)
        else $error("strobes not driven");
    read_drive_a: assert property (dev_d_oe |-> (rw && !transfer_ack_n))
        else $error("data driven outside read ack");
    quiet_off_a: assert property ((!slave_mode && !$past(slave_mode)
        && !$past(slave_mode, 2)) |-> (transfer_ack_n && transfer_error_ack_n && !dev_d_oe))
        else $error("bus driven outside slave mode");
endmodule // csbp_assertions

//--- test/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    import csbp_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic slave_mode = 1'b1;
    logic bus16_strap = 1'b1;
    logic share_all_addr = 1'b0;
    logic cmd_valid = 1'b0;
    logic cmd_ready;
    logic [31:0] cmd_addr = '0;
    logic cmd_write = 1'b0;
    logic [31:0] cmd_wdata = '0;
    logic [1:0] cmd_size = '0;
    logic [1:0] cmd_tt = '0;
    logic [2:0] cmd_tm = '0;
    logic rsp_valid, rsp_err, rsp_bi, rsp_last, eff_bus16, usr_req, usr_write, mem_sel, mem_write;
    logic [31:0] rsp_rdata, usr_wdata;
    logic [27:0] usr_addr, mem_addr;
    logic [3:0] usr_lanes, mem_lanes;
    logic [2:0] usr_tm;
    logic usr_ack = 1'b0;
    logic usr_err = 1'b0;
    logic [31:0] usr_rdata = '0;
    logic [34:0] q_rsp[$];
    logic [67:0] q_usr[$];
    logic [37:0] q_mem[$];
    logic cur_w, cur_line, resp_err = 1'b0, mem_prev = 1'b0;
    int resp_dly = 0;
    int err_count = 0;
    int checks = 0;

    always #2 mclk = ~mclk;

    // start and ack reach the device ungated
    csbp_bus_if u_csbp_bus_if();
    csbp_device u_csbp_device (.mclk(mclk), .rst(rst), .ce(1'b1), .bus(u_csbp_bus_if.dev),
        .slave_mode(slave_mode), .bus16_strap(bus16_strap), .share_all_addr(share_all_addr),
        .eff_bus16(eff_bus16), .usr_req(usr_req), .usr_addr(usr_addr), .usr_write(usr_write),
        .usr_wdata(usr_wdata), .usr_lanes(usr_lanes), .usr_tm(usr_tm), .usr_ack(usr_ack),
        .usr_err(usr_err), .usr_rdata(usr_rdata), .mem_sel(mem_sel), .mem_addr(mem_addr),
        .mem_lanes(mem_lanes), .mem_write(mem_write));
    csbp_host u_csbp_host (.mclk(mclk), .rst(rst), .ce(1'b1), .bus(u_csbp_bus_if.host),
        .share_all_addr(share_all_addr), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_addr(cmd_addr), .cmd_write(cmd_write), .cmd_wdata(cmd_wdata), .cmd_size(cmd_size),
        .cmd_tt(cmd_tt), .cmd_tm(cmd_tm), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .rsp_err(rsp_err), .rsp_bi(rsp_bi), .rsp_last(rsp_last));
    csbp_assertions u_chk (.mclk(mclk), .rst(rst), .slave_mode(slave_mode),
        .share_all_addr(share_all_addr), .transfer_start_n(u_csbp_bus_if.transfer_start_n),
        .addr(u_csbp_bus_if.addr), .rw(u_csbp_bus_if.rw),
        .access_width_code(u_csbp_bus_if.access_width_code),
        .transfer_type_code(u_csbp_bus_if.transfer_type_code), .dev_d_oe(u_csbp_bus_if.dev_d_oe),
        .dev_we_oe(u_csbp_bus_if.dev_we_oe), .transfer_ack_n(u_csbp_bus_if.transfer_ack_n),
        .transfer_error_ack_n(u_csbp_bus_if.transfer_error_ack_n),
        .burst_inhibit_n(u_csbp_bus_if.burst_inhibit_n));

    function automatic logic [3:0] exp_lanes(input logic [1:0] sz, input logic [1:0] a);
        if (sz == 2'h1)
            return 4'h8 >> a;
        if (sz == 2'h2)
            return a[1] ? 4'h3 : 4'hC;
        return 4'hF;
    endfunction

    task automatic cmp(input string nm, input logic [67:0] e, input logic [67:0] g);
        checks++;
        if (g !== e)
        begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_rsp();
        logic [34:0] e;
        e = q_rsp.size() ? q_rsp.pop_front() : 'x;
        cmp("host response", 68'(e), 68'({rsp_err, rsp_bi, rsp_last, rsp_rdata}));
    endtask

    task automatic chk_usr();
        logic [67:0] e;
        e = q_usr.size() ? q_usr.pop_front() : 'x;
        cmp("own request", 68'(e[67:32]),
            68'({usr_write, usr_tm, usr_lanes, usr_addr}));
        if (e[67] === 1'b1)
            cmp("own write data", 68'(e[31:0]), 68'(usr_wdata));
    endtask

    task automatic chk_mem();
        logic [37:0] e;
        e = q_mem.size() ? q_mem.pop_front() : 'x;
        cmp("memory cycle", 68'(e[32:0]), 68'({mem_write, mem_lanes, mem_addr}));
        if (e[37] === 1'b1)
            cmp("strobe pins", 68'(e[36:33]), 68'(u_csbp_bus_if.we_pins));
    endtask

    task automatic host_cmd(input logic [31:0] a, input logic w, input logic [1:0] sz,
                            input logic live);
        logic [31:0] wd;
        logic [3:0] ln;
        int n;
        wd = $urandom;
        ln = exp_lanes(sz, a[1:0]);
        n = 0;
        while (cmd_ready !== 1'b1 && n < 100)
        begin
            @(negedge mclk);
            n++;
        end
        cur_w = w;
        cur_line = (sz == CSBP_SZ_LINE);
        cmd_addr = a;
        cmd_write = w;
        cmd_size = sz;
        cmd_wdata = wd;
        cmd_tm = 3'($urandom);
        cmd_valid = 1'b1;
        if (live && a[27:16] == 12'hFFF)
            q_usr.push_back({w, cmd_tm, ln, a[27:0], wd});
        else if (live)
        begin
            // with shared address the pins carry the host's upper bits instead
            q_mem.push_back({w || share_all_addr, share_all_addr ? a[31:28] : ~ln,
                             w, ln, a[27:0]});
            q_rsp.push_back({1'b0, cur_line, 1'b1, 32'h0});
        end
        @(negedge mclk);
        cmd_valid = 1'b0;
    endtask

    task automatic report_and_stop();
        if (err_count == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial
    begin : responder
        logic [31:0] rd;
        forever
        begin
            @(negedge mclk);
            if (usr_req === 1'b1)
            begin
                repeat (resp_dly) @(negedge mclk);
                rd = $urandom;
                usr_rdata = rd;
                usr_ack = !resp_err;
                usr_err = resp_err;
                q_rsp.push_back({resp_err, cur_line && !resp_err, 1'b1,
                                 (cur_w || resp_err) ? 32'h0 : rd});
                @(negedge mclk);
                usr_ack = 1'b0;
                usr_err = 1'b0;
            end
        end
    end

    always @(negedge mclk)
    begin
        if (!rst && rsp_valid === 1'b1)
            chk_rsp();
        if (!rst && usr_req === 1'b1)
            chk_usr();
        if (!rst && mem_sel === 1'b1 && !mem_prev)
            chk_mem();
        mem_prev <= mem_sel;
    end

    initial
    begin : watchdog
        #(20000 * 4);
        err_count++;
        report_and_stop();
    end

    initial
    begin : main
        void'($urandom(45));
        repeat (3) @(negedge mclk);
        rst = 1'b0;
        @(negedge mclk);
        cmp("half width flag", 68'h0, 68'(eff_bus16));
        for (int s = 0; s < 4; s++)
            for (int k = 0; k < 8; k++)
            begin
                resp_dly = $urandom_range(2, 0);
                host_cmd({4'($urandom), 12'hFFF, 14'($urandom), k[1:0]}, k[2], 2'(s), 1'b1);
                host_cmd({4'h0, 1'b0, 25'($urandom), k[1:0]}, k[2], 2'(s), 1'b1);
            end
        resp_err = 1'b1;
        resp_dly = 1;
        host_cmd({4'h0, 12'hFFF, 16'h0102}, 1'b0, CSBP_SZ_WORD, 1'b1);
        host_cmd({4'h0, 12'hFFF, 16'h0103}, 1'b1, CSBP_SZ_BYTE, 1'b1);
        repeat (12) @(negedge mclk);
        resp_err = 1'b0;
        // upper address on the strobe pins needs a fresh reset
        rst = 1'b1;
        share_all_addr = 1'b1;
        repeat (3) @(negedge mclk);
        rst = 1'b0;
        host_cmd({4'h0, 12'hFFF, 16'h0010}, 1'b1, CSBP_SZ_LONG, 1'b1);
        host_cmd({4'hA, 1'b0, 27'($urandom)}, 1'b0, CSBP_SZ_WORD, 1'b1);
        host_cmd({4'h5, 1'b0, 27'($urandom)}, 1'b1, CSBP_SZ_LINE, 1'b1);
        // foreign transfer type: device must not answer, host waits until reset
        cmd_tt = 2'h1;
        host_cmd({4'h0, 12'hFFF, 16'h0020}, 1'b0, CSBP_SZ_LONG, 1'b0);
        repeat (12) @(negedge mclk);
        cmp("foreign type ignored", 68'h0, 68'(cmd_ready));
        // core running: device must stay off the bus, host hangs until reset
        rst = 1'b1;
        cmd_tt = 2'h0;
        share_all_addr = 1'b0;
        slave_mode = 1'b0;
        repeat (3) @(negedge mclk);
        rst = 1'b0;
        @(negedge mclk);
        cmp("half width flag", 68'h1, 68'(eff_bus16));
        host_cmd({4'h0, 1'b0, 27'h0000100}, 1'b1, CSBP_SZ_LONG, 1'b0);
        repeat (12) @(negedge mclk);
        rst = 1'b1;
        slave_mode = 1'b1;
        repeat (3) @(negedge mclk);
        rst = 1'b0;
        host_cmd({4'h0, 12'hFFF, 16'h0004}, 1'b0, CSBP_SZ_LINE, 1'b1);
        repeat (12) @(negedge mclk);
        cmp("pending notes", 68'h0, 68'(q_rsp.size() + q_usr.size() + q_mem.size()));
        report_and_stop();
    end
endmodule // tb_top
